//--- logic/mac_map.svh
// constants for the multiplexed converter control block
// included by the package and the top module; definitions only
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
`define MAC_RES_W 12
`define MAC_CFG_W 4
`define MAC_OUT_W 16
`define MAC_CLK_MHZ 250
`define MAC_ACQ_NS 150
`define MAC_ACQ_CYC ((`MAC_ACQ_NS * `MAC_CLK_MHZ + 999) / 1000)
`define MAC_RATE_KSPS 400
`define MAC_CONV_CYC ((`MAC_CLK_MHZ * 1000) / `MAC_RATE_KSPS)
`define MAC_BIT_CYC 40
`define MAC_FIFO_DEPTH 16
`define MAC_COM_SEL 4'h8
`endif

//--- logic/mac_pkg.sv
// types shared by the converter control block
// relies on mac_map.svh for widths
`include "mac_map.svh"
package mac_pkg;
    typedef enum logic [1:0] {
        MAC_IDLE,
        MAC_CONV,
        MAC_ACQ
    } mac_state_t;
    typedef struct packed {
        logic pair_select;
        logic [2:0] chan_addr;
        logic polarity_sel;
        logic gain_sel;
    } mac_cfg_t;
    typedef struct packed {
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
    } mac_route_t;
    typedef struct packed {
        logic [`MAC_CFG_W-1:0] word;
        logic [`MAC_RES_W-1:0] result;
    } mac_sample_t;
endpackage

//--- logic/mac_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
// single clock, async active-low reset
`timescale 1ns/100ps
module mac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    // honest full/empty from the occupancy count
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];
    // storage carries no reset, only pointers and count do
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    // pointers and count
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- logic/mac_ctrl.sv
// conversion control for an eight-channel sampling converter
// assumes all pins synchronous to sys_clk_i; comparator decision arrives as a level
// Overview of operation
// - a conversion starts only when chip select and sample trigger are both active.
// - the approximation register is cleared when a conversion begins, before any decision.
// - start requests during a conversion are ignored; no restart until done.
// - result bits are resolved one per step from msb down to lsb.
// - at the end the result and the 4-bit config word load into a 16-bit latch.
// - the conversion timing allows throughput up to 400ksps.
// - mux config comes from pair select, three address lines, polarity and gain.
// - pair select low gives eight single-ended channels, high gives four pairs.
// - single-ended address n routes input n positive and the common input negative.
// - a conversion begins on the falling edge of the sample trigger.
// - trigger and read are honoured only while chip select is low.
// - output drivers are enabled only while read and chip select are both low.
// - the write strobe low passes config through and its rising edge latches it.
`timescale 1ns/100ps
`include "mac_map.svh"
module mac_ctrl (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic chip_sel_n_i,
    input wire logic sample_trigger_n_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic power_down_n_i,
    input wire logic pair_select_i,
    input wire logic [2:0] chan_addr_i,
    input wire logic polarity_sel_i,
    input wire logic gain_sel_i,
    input wire logic cmp_high_i,
    output logic [`MAC_RES_W-1:0] dac_code_o,
    output logic sample_hold_o,
    output logic [3:0] mux_pos_o,
    output logic [3:0] mux_neg_o,
    output logic polarity_o,
    output logic gain_o,
    output logic busy_o,
    output logic [`MAC_OUT_W-1:0] data_o,
    output logic data_oe_n_o,
    output logic [`MAC_OUT_W-1:0] stream_data_o,
    output logic stream_valid_o,
    input wire logic stream_ready_i,
    output logic overrun_o
);
    mac_pkg::mac_state_t state_q;
    mac_pkg::mac_cfg_t cfg_in;
    mac_pkg::mac_cfg_t cfg_q;
    mac_pkg::mac_cfg_t cfg_use;
    mac_pkg::mac_cfg_t conv_cfg_q;
    mac_pkg::mac_route_t route;
    mac_pkg::mac_sample_t out_q;
    logic [`MAC_RES_W-1:0] sar_q;
    logic [`MAC_RES_W-1:0] trial_q;
    logic [5:0] step_q;
    logic [3:0] bit_q;
    logic [5:0] acq_q;
    logic trig_q;
    logic start;
    logic bit_done;
    logic fifo_ready;
    logic push_q;

    assign cfg_in = '{pair_select_i, chan_addr_i, polarity_sel_i, gain_sel_i};
    // write strobe low is transparent; the held copy is what its rising edge left
    assign cfg_use = write_n_i ? cfg_q : cfg_in;

    // config latch updated while write is low, so it holds the value at the rising edge
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= '0;
        end else if (!write_n_i) begin
            cfg_q <= cfg_in;
        end
    end

    // mux routing: single-ended uses common as negative, pairs swap on address lsb
    always_comb begin
        if (cfg_use.pair_select) begin
            route.pos_sel = {1'b0, cfg_use.chan_addr};
            route.neg_sel = {1'b0, cfg_use.chan_addr[2:1], ~cfg_use.chan_addr[0]};
        end else begin
            route.pos_sel = {1'b0, cfg_use.chan_addr};
            route.neg_sel = `MAC_COM_SEL;
        end
    end
    assign mux_pos_o = route.pos_sel;
    assign mux_neg_o = route.neg_sel;
    assign polarity_o = cfg_use.polarity_sel;
    assign gain_o = cfg_use.gain_sel;

    // trigger edge detector; chip select qualifies it, power down blocks it
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_q <= 1'b1;
        end else begin
            trig_q <= sample_trigger_n_i;
        end
    end
    assign start = trig_q && !sample_trigger_n_i && !chip_sel_n_i && power_down_n_i;

    // bit timer: each decision gets a fixed slot so 12 bits fit a 400ksps frame
    assign bit_done = (step_q == 6'(`MAC_BIT_CYC - 1));

    // sequencer; a start outside idle is simply not looked at
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= mac_pkg::MAC_IDLE;
        end else begin
            case (state_q)
                mac_pkg::MAC_IDLE: begin
                    if (start) begin
                        state_q <= mac_pkg::MAC_CONV;
                    end
                end
                mac_pkg::MAC_CONV: begin
                    if (bit_done && bit_q == 4'h0) begin
                        state_q <= mac_pkg::MAC_ACQ;
                    end
                end
                mac_pkg::MAC_ACQ: begin
                    // acquisition window also paces the next start
                    if (acq_q == 6'(`MAC_ACQ_CYC - 1)) begin
                        state_q <= mac_pkg::MAC_IDLE;
                    end
                end
                default: begin
                    state_q <= mac_pkg::MAC_IDLE;
                end
            endcase
        end
    end

    // step, bit index and acquisition counters
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_q <= '0;
            bit_q <= '0;
            acq_q <= '0;
        end else if (state_q == mac_pkg::MAC_IDLE) begin
            step_q <= '0;
            bit_q <= 4'(`MAC_RES_W - 1);
            acq_q <= '0;
        end else if (state_q == mac_pkg::MAC_CONV) begin
            step_q <= bit_done ? 6'h00 : step_q + 6'h01;
            if (bit_done) begin
                bit_q <= bit_q - 4'h1;
            end
        end else begin
            acq_q <= acq_q + 6'h01;
        end
    end

    // approximation register: cleared at start, then trial bit walks msb to lsb
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sar_q <= '0;
            trial_q <= '0;
        end else if (state_q == mac_pkg::MAC_IDLE && start) begin
            sar_q <= '0;
            trial_q <= {1'b1, {(`MAC_RES_W-1){1'b0}}};
        end else if (state_q == mac_pkg::MAC_CONV && bit_done) begin
            // keep the trial bit when the input stays above the dac level
            sar_q <= cmp_high_i ? (sar_q | trial_q) : sar_q;
            trial_q <= trial_q >> 1;
        end
    end
    assign dac_code_o = sar_q | trial_q;
    assign sample_hold_o = (state_q == mac_pkg::MAC_CONV);
    assign busy_o = (state_q == mac_pkg::MAC_CONV);

    // channel word taken at the start, so a config change mid-conversion cannot mislabel the result
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_cfg_q <= '0;
        end else if (state_q == mac_pkg::MAC_IDLE && start) begin
            conv_cfg_q <= cfg_use;
        end
    end

    // output latch: result plus config word, held until the next completion
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_q <= '0;
            push_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (state_q == mac_pkg::MAC_CONV && bit_done && bit_q == 4'h0) begin
                out_q.word <= {conv_cfg_q.pair_select, conv_cfg_q.chan_addr};
                out_q.result <= cmp_high_i ? (sar_q | trial_q) : sar_q;
                push_q <= 1'b1;
            end
        end
    end
    assign data_o = out_q;
    assign data_oe_n_o = read_n_i || chip_sel_n_i;

    // a full queue drops the sample rather than stall the analog timing
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overrun_o <= 1'b0;
        end else begin
            overrun_o <= push_q && !fifo_ready;
        end
    end

    mac_fifo #(
        .WIDTH(`MAC_OUT_W),
        .DEPTH(`MAC_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_q),
        .in_ready_o(fifo_ready),
        .in_data_i(out_q),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .out_data_o(stream_data_o)
    );
endmodule

//--- tb/mac_ctrl_props.sv
// port checker for the converter control block
// bound to each mac_ctrl; sees its ports only, one clock domain
`timescale 1ns/100ps
`include "mac_map.svh"
module mac_ctrl_props (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic chip_sel_n_i,
    input wire logic sample_trigger_n_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic pair_select_i,
    input wire logic [2:0] chan_addr_i,
    input wire logic [`MAC_RES_W-1:0] dac_code_o,
    input wire logic [3:0] mux_pos_o,
    input wire logic [3:0] mux_neg_o,
    input wire logic busy_o,
    input wire logic [`MAC_OUT_W-1:0] data_o,
    input wire logic data_oe_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [9:0] run_q;
    logic [7:0] gap_q;
    // busy length and idle gap; gap saturates so a fresh reset counts as rested
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q <= 10'h0;
            gap_q <= 8'hff;
        end else begin
            run_q <= busy_o ? run_q + 10'h1 : 10'h0;
            gap_q <= busy_o ? 8'h0 : (gap_q == 8'hff ? gap_q : gap_q + 8'h1);
        end
    end
    a_oe_read_sel: assert property (data_oe_n_o == (read_n_i | chip_sel_n_i)) else $error("oe wrong");
    a_start_joint: assert property ($rose(busy_o) |-> !$past(chip_sel_n_i) && !$past(sample_trigger_n_i))
        else $error("start without select");
    a_start_fall: assert property ($rose(busy_o) |-> $past(sample_trigger_n_i, 2)) else $error("no edge");
    a_sar_clear: assert property ($rose(busy_o) |-> dac_code_o == 12'h800) else $error("sar not clear");
    a_msb_first: assert property ($rose(busy_o) |-> ##60 dac_code_o[10:0] == 11'h400) else $error("bit order");
    a_conv_len: assert property ($fell(busy_o) |-> run_q == 10'h1e0) else $error("length");
    a_acq_gap: assert property ($rose(busy_o) |-> gap_q >= 8'h26) else $error("restart early");
    a_data_hold: assert property ($changed(data_o) |-> $fell(busy_o)) else $error("data moved");
    a_mux_route: assert property (!write_n_i && !busy_o |-> mux_pos_o == {1'b0, chan_addr_i} &&
        mux_neg_o == (pair_select_i ? {1'b0, chan_addr_i ^ 3'h1} : 4'h8)) else $error("route");
    c_start: cover property ($rose(busy_o));
    c_done: cover property ($fell(busy_o));
    c_latch: cover property ($rose(write_n_i));
endmodule
bind mac_ctrl mac_ctrl_props i_props (.*);

//--- tb/mac_cmp_model.sv
// comparator stand-in for the far analog side
// the bench sets the held input level; answers each trial code at once
`timescale 1ns/100ps
module mac_cmp_model (
    input wire logic [11:0] level_i,
    input wire logic [11:0] dac_code_i,
    output logic cmp_high_o
);
    // at or above the trial keeps the bit, so the search lands on level_i
    assign cmp_high_o = (level_i >= dac_code_i);
endmodule

//--- tb/mux_adc_conversion_control_tb_top.sv
// bench for the converter control block
// host strobes driven 1ns after each edge; comparator model closes the loop
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("ERROR %s %h %h", n, e, s); end end
module mux_adc_conversion_control_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, trig_n = 1'b1, rd_n = 1'b1, wr_n = 1'b0, pd_n = 1'b1;
    logic pair = 1'b0, rdy = 1'b1, seen = 1'b0, cmp, busy, oe_n, valid, ovr;
    logic pol_sel = 1'b0, gsel = 1'b0, sh, pol, gain;
    logic [3:0] mpos, mneg;
    logic [2:0] addr = 3'h0;
    logic [11:0] lvl = 12'h0, dac;
    logic [15:0] dout, sdat;
    int err_total = 0, check_count = 0, cyc = 0, i;
    always #2 clk = ~clk;
    mac_cmp_model i_cmp (.level_i(lvl), .dac_code_i(dac), .cmp_high_o(cmp));
    mac_ctrl i_dut (.sys_clk_i(clk), .arst_n_i(rst_n), .chip_sel_n_i(cs_n), .sample_trigger_n_i(trig_n),
        .read_n_i(rd_n), .write_n_i(wr_n), .power_down_n_i(pd_n), .pair_select_i(pair), .chan_addr_i(addr),
        .polarity_sel_i(pol_sel), .gain_sel_i(gsel), .cmp_high_i(cmp), .dac_code_o(dac), .sample_hold_o(sh),
        .mux_pos_o(mpos), .mux_neg_o(mneg), .polarity_o(pol), .gain_o(gain), .busy_o(busy), .data_o(dout),
        .data_oe_n_o(oe_n), .stream_data_o(sdat), .stream_valid_o(valid), .stream_ready_i(rdy), .overrun_o(ovr));
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic trig(input logic cs);
        cs_n = cs;
        trig_n = 1'b0;
        tk(1);
        trig_n = 1'b1;
        cs_n = 1'b1;
        tk(1);
    endtask
    // one conversion; latch and, when not stalled, stream word
    task automatic conv(input logic [11:0] v, input logic [15:0] w);
        lvl = v;
        trig(1'b0);
        `CHK("busy", 1'b1, busy)
        `CHK("hold", 1'b1, sh)
        for (i = 0; i < 600 && busy !== 1'b0; i++) tk(1);
        `CHK("hold off", 1'b0, sh)
        `CHK("data", w, dout)
        for (i = 0; i < 4 && rdy && valid !== 1'b1; i++) tk(1);
        if (rdy) `CHK("stream", w, sdat)
        tk(40);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // overrun is a one-cycle pulse, so catch it here
    always @(posedge clk) begin
        cyc++;
        if (ovr === 1'b1) seen = 1'b1;
        if (cyc == 30000) begin
            err_total++;
            $display("ERROR timeout");
            results();
        end
    end
    // eight single-ended channels then four pairs in both orders; polarity and gain pass through
    task automatic mux_test;
        for (int k = 0; k < 16; k++) begin
            pair = k[3];
            addr = k[2:0];
            pol_sel = k[1] ^ k[3];
            gsel = ~k[0];
            conv({k[3:0], 8'h5a}, {k[3:0], k[3:0], 8'h5a});
            `CHK("polarity", k[1] ^ k[3], pol)
            `CHK("gain", ~k[0], gain)
        end
        $display("mux test done");
    endtask
    // starts that must be ignored: deselected, powered down, busy, acquiring, trigger held low
    task automatic refuse_test;
        trig(1'b1);
        `CHK("cs high", 1'b0, busy)
        pd_n = 1'b0;
        trig(1'b0);
        `CHK("power down", 1'b0, busy)
        pd_n = 1'b1;
        lvl = 12'h000;
        trig(1'b0);
        tk(100);
        trig(1'b0);
        tk(370);
        `CHK("busy held", 1'b1, busy)
        tk(10);
        `CHK("done", 16'hf000, dout)
        trig(1'b0);
        `CHK("acq start", 1'b0, busy)
        tk(40);
        for (i = 0; i < 4; i++) begin
            rd_n = i[0];
            cs_n = i[1];
            tk(1);
            `CHK("oe", i[0] | i[1], oe_n)
        end
        // a trigger held low past the acquisition window must not start a second conversion
        lvl = 12'h0a5;
        cs_n = 1'b0;
        trig_n = 1'b0;
        tk(540);
        `CHK("level hold", 1'b0, busy)
        `CHK("level data", 16'hf0a5, dout)
        trig_n = 1'b1;
        cs_n = 1'b1;
        tk(1);
        $display("refuse test done");
    endtask
    // rising write edge latches the routing; later pin changes must not reach mux or word
    task automatic latch_test;
        pair = 1'b1;
        addr = 3'h5;
        tk(1);
        wr_n = 1'b1;
        tk(1);
        pair = 1'b0;
        addr = 3'h2;
        tk(1);
        `CHK("latched pos", 4'h5, mpos)
        `CHK("latched neg", 4'h4, mneg)
        conv(12'hfff, 16'hdfff);
        wr_n = 1'b0;
        tk(1);
        `CHK("open pos", 4'h2, mpos)
        `CHK("open neg", 4'h8, mneg)
        $display("latch test done");
    endtask
    // stalled stream: sixteen words fit, the seventeenth is dropped with an overrun pulse
    task automatic fifo_test;
        rdy = 1'b0;
        for (int k = 0; k < 17; k++) begin
            conv(12'h100 + k[11:0], 16'h2100 + k[15:0]);
            if (k == 15) `CHK("no overrun", 1'b0, seen)
        end
        `CHK("overrun", 1'b1, seen)
        rdy = 1'b1;
        for (int k = 0; k < 16; k++) begin
            `CHK("drain", 16'h2100 + k[15:0], sdat)
            tk(1);
        end
        `CHK("empty", 1'b0, valid)
        $display("fifo test done");
    endtask
    // reset in mid-conversion, then a fresh conversion whose address moves while busy
    task automatic reset_test;
        trig(1'b0);
        tk(50);
        rst_n = 1'b0;
        tk(1);
        `CHK("reset busy", 1'b0, busy)
        `CHK("reset data", 16'h0, dout)
        `CHK("reset queue", 1'b0, valid)
        rst_n = 1'b1;
        tk(2);
        lvl = 12'h3c5;
        trig(1'b0);
        addr = 3'h6;
        `CHK("restart", 1'b1, busy)
        for (i = 0; i < 600 && busy !== 1'b0; i++) tk(1);
        `CHK("word at start", 16'h23c5, dout)
        tk(40);
        $display("reset test done");
    endtask
    initial begin
        tk(2);
        rst_n = 1'b1;
        tk(2);
        mux_test();
        refuse_test();
        latch_test();
        fifo_test();
        reset_test();
        results();
    end
endmodule
